// >>> gwm_gpio_consts.vh
// How it works
// - Writing one to output_write_disable stops output data writes reaching that line.
// - Writes to output write enable/disable are ignored while write protection is on.
// - output_write_state bit reads one when output data writes drive that line.
// - Writing one to extra_irq_mode_enable selects the chosen edge/level and polarity event.
// - Writing one to extra_irq_mode_disable returns the line to both-edge detection.
// - extra_irq_mode_state reads zero for both edges, one for the selected event.
// - Writing one to irq_edge_select sets edge detection; zero bits change nothing.
// - Writing one to irq_level_select sets level detection; zero bits change nothing.
// - irq_edge_level_state reads zero for edge, one for level detection.
// - Writing one to irq_fall_low_select chooses falling edge or low level.
// - Writing one to output_write_enable lets output data writes drive that line.
// - Writing one to irq_rise_high_select chooses rising edge or high level.
// - Write protection bit changes only when the key field holds 0x50494F.
// - irq_polarity_state reads zero for falling/low, one for rising/high.
`ifndef GWM_GPIO_CONSTS_VH
`define GWM_GPIO_CONSTS_VH

// Register byte addresses
`define GWM_ADR_OWE 32'h400e0ea0
`define GWM_ADR_OWD 32'h400e0ea4
`define GWM_ADR_OWS 32'h400e0ea8
`define GWM_ADR_AIME 32'h400e0eb0
`define GWM_ADR_AIMD 32'h400e0eb4
`define GWM_ADR_AIMS 32'h400e0eb8
`define GWM_ADR_ESEL 32'h400e0ec0
`define GWM_ADR_LSEL 32'h400e0ec4
`define GWM_ADR_ELS 32'h400e0ec8
`define GWM_ADR_FLSEL 32'h400e0ed0
`define GWM_ADR_RHSEL 32'h400e0ed4
`define GWM_ADR_POLS 32'h400e0ed8
`define GWM_ADR_WPM 32'h400e0ee4
`define GWM_ADR_ODATA 32'h400e0f40
`define GWM_ADR_ISTAT 32'h400e0f44
`define GWM_ADR_IMASK 32'h400e0f48

// Write protect mode register fields
`define GWM_WRITE_PROTECT_ENABLE_BIT 0
`define GWM_KEY_MSB 31
`define GWM_KEY_LSB 8
`define GWM_KEY_VALUE 24'h50494f

// Reset values
`define GWM_RST_WORD 32'h00000000
`define GWM_RST_BIT 1'h0

`endif

// >>> gwm_gpio_mask.v
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "gwm_gpio_consts.vh"

module gwm_gpio_mask #(
  parameter LINES = 32
) (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // I/O lines
  input wire [LINES-1:0] padIn,
  output reg [LINES-1:0] lineOut,
  // Interrupt
  output reg irq
);

  // Configuration state
  reg [LINES-1:0] outWrState;
  reg [LINES-1:0] extraMode;
  reg [LINES-1:0] edgeLevel;
  reg [LINES-1:0] polarity;
  reg wpEnable;
  reg [LINES-1:0] irqStatus;
  reg [LINES-1:0] irqMask;

  // Pad synchroniser and history
  reg [LINES-1:0] padMeta;
  reg [LINES-1:0] padSync;
  reg [LINES-1:0] padPrev;

  // Bus decode
  wire access;
  wire wrStrobe;
  wire [31:0] selMask;
  wire [31:0] wrData;
  wire [LINES-1:0] wrBits;
  wire keyOk;

  // Per-line events
  wire [LINES-1:0] lineEvent;

  // Next values
  reg [LINES-1:0] next_outWrState;
  reg [LINES-1:0] next_extraMode;
  reg [LINES-1:0] next_edgeLevel;
  reg [LINES-1:0] next_polarity;
  reg next_wpEnable;
  reg [LINES-1:0] next_irqStatus;
  reg [LINES-1:0] next_irqMask;
  reg [LINES-1:0] next_lineOut;
  reg [31:0] next_rdData;

  // One access per request; the ack cycle itself is not a new access
  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrStrobe = access & wb_we_i;

  // Byte lanes that are not selected write as zero, which is no effect except at ODATA, IMASK and the WPM protect bit
  assign selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wrData = wb_dat_i & selMask;
  assign wrBits = wrData[LINES-1:0];

  // Key must sit in the key field for the protect bit to move
  assign keyOk = (wrData[`GWM_KEY_MSB:`GWM_KEY_LSB] == `GWM_KEY_VALUE);

  // Pads come from outside the clock domain: two flops, then history
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      padMeta <= {LINES{`GWM_RST_BIT}};
      padSync <= {LINES{`GWM_RST_BIT}};
      padPrev <= {LINES{`GWM_RST_BIT}};
    end else begin
      padMeta <= padIn;
      padSync <= padMeta;
      padPrev <= padSync;
    end
  end

  // Event detection, one slice per line
  genvar n;
  generate
    for (n = 0; n < LINES; n = n + 1) begin : gLine
      wire rise;
      wire fall;
      wire chosenEdge;
      wire chosenLevel;
      assign rise = padSync[n] & ~padPrev[n];
      assign fall = ~padSync[n] & padPrev[n];
      // Polarity one means rising or high
      assign chosenEdge = polarity[n] ? rise : fall;
      assign chosenLevel = polarity[n] ? padSync[n] : ~padSync[n];
      // Default mode catches both edges; extra mode uses edge/level choice
      assign lineEvent[n] = extraMode[n] ?
        (edgeLevel[n] ? chosenLevel : chosenEdge) : (rise | fall);
    end
  endgenerate

  // Register writes and sticky status
  always @* begin
    next_outWrState = outWrState;
    next_extraMode = extraMode;
    next_edgeLevel = edgeLevel;
    next_polarity = polarity;
    next_wpEnable = wpEnable;
    next_irqMask = irqMask;
    next_lineOut = lineOut;
    next_irqStatus = irqStatus;
    if (wrStrobe) begin
      case (wb_adr_i)
        `GWM_ADR_OWE: begin
          // Protected writes are dropped silently
          if (!wpEnable) begin
            next_outWrState = outWrState | wrBits;
          end
        end
        `GWM_ADR_OWD: begin
          if (!wpEnable) begin
            next_outWrState = outWrState & ~wrBits;
          end
        end
        `GWM_ADR_AIME: begin
          next_extraMode = extraMode | wrBits;
        end
        `GWM_ADR_AIMD: begin
          next_extraMode = extraMode & ~wrBits;
        end
        `GWM_ADR_ESEL: begin
          next_edgeLevel = edgeLevel & ~wrBits;
        end
        `GWM_ADR_LSEL: begin
          next_edgeLevel = edgeLevel | wrBits;
        end
        `GWM_ADR_FLSEL: begin
          next_polarity = polarity & ~wrBits;
        end
        `GWM_ADR_RHSEL: begin
          next_polarity = polarity | wrBits;
        end
        `GWM_ADR_WPM: begin
          if (keyOk) begin
            next_wpEnable = wrData[`GWM_WRITE_PROTECT_ENABLE_BIT];
          end
        end
        `GWM_ADR_ODATA: begin
          // Only lines whose writes are enabled follow the data
          next_lineOut = (lineOut & ~outWrState) | (wrBits & outWrState);
        end
        `GWM_ADR_ISTAT: begin
          next_irqStatus = irqStatus & ~wrBits;
        end
        `GWM_ADR_IMASK: begin
          next_irqMask = wrBits;
        end
        default: begin
          next_irqMask = irqMask;
        end
      endcase
    end
    // A fresh event beats a clear in the same cycle
    next_irqStatus = next_irqStatus | lineEvent;
  end

  // Read multiplexer; unmapped and write-only words read zero
  always @* begin
    next_rdData = `GWM_RST_WORD;
    case (wb_adr_i)
      `GWM_ADR_OWS: begin
        next_rdData[LINES-1:0] = outWrState;
      end
      `GWM_ADR_AIMS: begin
        next_rdData[LINES-1:0] = extraMode;
      end
      `GWM_ADR_ELS: begin
        next_rdData[LINES-1:0] = edgeLevel;
      end
      `GWM_ADR_POLS: begin
        next_rdData[LINES-1:0] = polarity;
      end
      `GWM_ADR_WPM: begin
        // Key field always reads zero
        next_rdData[`GWM_WRITE_PROTECT_ENABLE_BIT] = wpEnable;
      end
      `GWM_ADR_ODATA: begin
        next_rdData[LINES-1:0] = lineOut;
      end
      `GWM_ADR_ISTAT: begin
        next_rdData[LINES-1:0] = irqStatus;
      end
      `GWM_ADR_IMASK: begin
        next_rdData[LINES-1:0] = irqMask;
      end
      default: begin
        next_rdData = `GWM_RST_WORD;
      end
    endcase
  end

  // State registers
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      outWrState <= {LINES{`GWM_RST_BIT}};
      extraMode <= {LINES{`GWM_RST_BIT}};
      edgeLevel <= {LINES{`GWM_RST_BIT}};
      polarity <= {LINES{`GWM_RST_BIT}};
      wpEnable <= `GWM_RST_BIT;
      irqStatus <= {LINES{`GWM_RST_BIT}};
      irqMask <= {LINES{`GWM_RST_BIT}};
      lineOut <= {LINES{`GWM_RST_BIT}};
    end else begin
      outWrState <= next_outWrState;
      extraMode <= next_extraMode;
      edgeLevel <= next_edgeLevel;
      polarity <= next_polarity;
      wpEnable <= next_wpEnable;
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      lineOut <= next_lineOut;
    end
  end

  // Interrupt from the next status so it rises with the sticky bit
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= `GWM_RST_BIT;
    end else begin
      irq <= |(next_irqStatus & next_irqMask);
    end
  end

  // Bus answer: one wait state, ack lasts one cycle
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= `GWM_RST_BIT;
      wb_dat_o <= `GWM_RST_WORD;
    end else begin
      wb_ack_o <= access;
      if (access && !wb_we_i) begin
        wb_dat_o <= next_rdData;
      end
    end
  end

endmodule // gwm_gpio_mask

// >>> gwm_gpio_mask_test.sv
`timescale 1ns/1ps
`include "gwm_gpio_consts.vh"
module gwm_gpio_mask_test;
  logic clock = 0, arst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [31:0] wb_adr_i = 0, wb_dat_i = 0, level = 0, rdat;
  logic [3:0] wb_sel_i = 4'hf;
  wire [31:0] wb_dat_o, padIn, lineOut;
  wire wb_ack_o, irq;
  int n_errors = 0, num_checks = 0;
  initial forever #5 clock = ~clock;
  gwm_gpio_mask dut (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .padIn(padIn), .lineOut(lineOut), .irq(irq));
  gwm_pad_model pads (.clock(clock), .level(level), .padIn(padIn));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; waits on ack, never on a fixed count
  task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clock);
    while (wb_ack_o !== 1'b1 && k < 20) begin
      k++;
      @(posedge clock);
    end
    chk("ack", 1, wb_ack_o);
    rdat = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
    bus(0, a, 0);
    chk(nm, e, rdat);
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well past the hundred-odd cycles the tests need
  initial begin
    #100000;
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1;
    rd(`GWM_ADR_OWS, 0, "ows reset");
    rd(`GWM_ADR_AIMS, 0, "aims reset");
    bus(1, `GWM_ADR_OWE, 32'h000000ff);
    bus(1, `GWM_ADR_ODATA, 32'hffffffff);
    rd(`GWM_ADR_ODATA, 32'h000000ff, "odata");
    bus(1, `GWM_ADR_OWD, 32'h0000000f);
    rd(`GWM_ADR_OWS, 32'h000000f0, "ows");
    bus(1, `GWM_ADR_ODATA, 32'h0);
    chk("lineOut", 32'h0000000f, lineOut);
    bus(1, `GWM_ADR_WPM, 32'h50494f01);
    bus(1, `GWM_ADR_OWD, 32'h000000ff);
    bus(1, `GWM_ADR_WPM, 32'h50494e00);
    bus(1, `GWM_ADR_OWE, 32'h00000f00);
    rd(`GWM_ADR_OWS, 32'h000000f0, "ows locked");
    bus(1, `GWM_ADR_WPM, 32'h50494f00);
    bus(1, `GWM_ADR_OWE, 32'h00000100);
    rd(`GWM_ADR_OWS, 32'h000001f0, "ows open");
    // Unselected byte lanes carry no set bits
    wb_sel_i <= 4'h1;
    bus(1, `GWM_ADR_OWE, 32'hffff0000);
    wb_sel_i <= 4'hf;
    rd(`GWM_ADR_OWS, 32'h000001f0, "ows lanes");
    rd(`GWM_ADR_WPM, 0, "wpm");
    rd(32'h400e0efc, 0, "unmapped");
    bus(1, `GWM_ADR_AIME, 32'h3);
    bus(1, `GWM_ADR_AIMD, 32'h1);
    rd(`GWM_ADR_AIMS, 32'h2, "aims");
    bus(1, `GWM_ADR_LSEL, 32'h6);
    bus(1, `GWM_ADR_ESEL, 32'h4);
    rd(`GWM_ADR_ELS, 32'h2, "els");
    bus(1, `GWM_ADR_RHSEL, 32'h2);
    rd(`GWM_ADR_POLS, 32'h2, "pols");
    bus(1, `GWM_ADR_FLSEL, 32'h2);
    rd(`GWM_ADR_POLS, 0, "pols fall");
    // Line 1 low level keeps its bit set through a clear
    bus(1, `GWM_ADR_IMASK, 32'h1);
    rd(`GWM_ADR_IMASK, 32'h1, "imask");
    bus(1, `GWM_ADR_ISTAT, 32'hffffffff);
    rd(`GWM_ADR_ISTAT, 32'h2, "low level");
    chk("irq masked", 0, irq);
    level <= 32'h3;
    repeat (6) @(posedge clock);
    chk("irq rise", 1, irq);
    bus(1, `GWM_ADR_ISTAT, 32'hffffffff);
    rd(`GWM_ADR_ISTAT, 0, "cleared");
    chk("irq clear", 0, irq);
    bus(1, `GWM_ADR_ESEL, 32'h2);
    level <= 32'h0;
    repeat (6) @(posedge clock);
    rd(`GWM_ADR_ISTAT, 32'h3, "falls");
    bus(1, `GWM_ADR_IMASK, 32'h0);
    chk("irq mask", 0, irq);
    end_of_test;
  end
endmodule // gwm_gpio_mask_test

// >>> gwm_gpio_props.sv
`timescale 1ns/1ps
`include "gwm_gpio_consts.vh"
module gwm_gpio_props #(parameter LINES = 32) (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Line side
  input wire [LINES-1:0] lineOut,
  input wire irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Request taken at this edge
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd = take && !wb_we_i;
  wire wr = take && wb_we_i;
  ack_once_a: assert property (take |=> wb_ack_o) else $error("ack late");
  ack_cause_a: assert property (!take |=> !wb_ack_o) else $error("stray ack");
  wo_zero_a: assert property (rd && (wb_adr_i == `GWM_ADR_OWD || wb_adr_i == `GWM_ADR_AIME)
    |=> wb_dat_o == 32'h0) else $error("write-only read not zero");
  key_zero_a: assert property (rd && wb_adr_i == `GWM_ADR_WPM
    |=> wb_dat_o[31:8] == 24'h0) else $error("key read back");
  unmapped_zero_a: assert property (rd && wb_adr_i == 32'h400e0efc
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  dat_hold_a: assert property (!rd |=> $stable(wb_dat_o)) else $error("read data moved");
  line_hold_a: assert property (!(wr && wb_adr_i == `GWM_ADR_ODATA)
    |=> $stable(lineOut)) else $error("line changed without write");
  // Only a status clear or a mask write can drop the interrupt
  irq_fall_a: assert property ($fell(irq) |-> $past(wr &&
    (wb_adr_i == `GWM_ADR_ISTAT || wb_adr_i == `GWM_ADR_IMASK))) else $error("irq fell");
endmodule // gwm_gpio_props
bind gwm_gpio_mask gwm_gpio_props #(.LINES(LINES)) u_props (.clock(clock), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lineOut(lineOut), .irq(irq));

// >>> gwm_pad_model.sv
`timescale 1ns/1ps
module gwm_pad_model (
  // Clock
  input wire clock,
  // Level asked for by the test
  input wire [31:0] level,
  // Pads toward the block
  output logic [31:0] padIn = 32'h0
);
  // Pads move after an edge, so a change is seen one edge later
  always @(posedge clock) padIn <= level;
endmodule // gwm_pad_model
